/* ise_core.sv */
module ise_core #(
    parameter int BANK_W = 4,
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RST,
    // instruction stream
    input  wire logic [15:0]       INSTR,
    input  wire logic              INSTR_VALID,
    input  wire logic              NEXT_TWO_WORD,
    output logic                   INSTR_READY,
    output logic                   FLUSH,
    // addressing configuration
    input  wire logic              EXT_SET_EN,
    input  wire logic [BANK_W-1:0] BANK_SELECT_REGISTER,
    input  wire logic [ADDR_W-1:0] INDEX_BASE,
    // data memory
    output logic [ADDR_W-1:0]      MEM_ADDR,
    input  wire logic [7:0]        MEM_RDATA,
    output logic                   MEM_WE,
    output logic [7:0]             MEM_WDATA,
    // accumulator and status
    output logic [7:0]             ACCUM,
    output logic                   FLAG_ZERO,
    output logic                   FLAG_CARRY,
    output logic                   DIGIT_CARRY_FLAG,
    output logic                   FLAG_NEG,
    output logic                   FLAG_OVF
);
    if (ADDR_W != 12 || BANK_W != 4) begin : g_chk
        $error("ise_core supports only a 12-bit address with a 4-bit bank");
    end

    ise_pkg::ise_regs_t r;
    ise_pkg::ise_regs_t next_r;
    ise_alu_if          alu_bus ();
    logic               taken;
    logic [7:0]         fsel;
    logic               acc_bit;
    logic               skip_now;

    ise_alu u_alu (.a(alu_bus));

    assign alu_bus.opnd = r.opnd;
    assign fsel         = INSTR[ise_pkg::FILE_HI:0];
    assign acc_bit      = INSTR[ise_pkg::ACC_BIT];
    assign INSTR_READY  = (r.state == ise_pkg::ISE_EXEC) && (r.phase == ise_pkg::PH_DECODE);
    assign taken        = INSTR_READY && INSTR_VALID;
    assign skip_now     = r.active && (r.kind == ise_pkg::ISE_INCSZ)
                          && (r.phase == ise_pkg::PH_WRITE) && (r.result == 8'h00);
    assign FLUSH        = skip_now;
    assign MEM_WE       = r.active && (r.kind != ise_pkg::ISE_OTHER)
                          && (r.phase == ise_pkg::PH_WRITE) && r.dest;
    assign MEM_ADDR     = r.addr;
    assign MEM_WDATA    = r.result;
    assign ACCUM        = r.accum;
    assign FLAG_ZERO    = r.zero;
    assign FLAG_CARRY   = r.carry;
    assign DIGIT_CARRY_FLAG = r.dcarry;
    assign FLAG_NEG     = r.neg;
    assign FLAG_OVF     = r.ovf;

    always_comb begin
        next_r       = r;
        next_r.phase = r.phase + 2'h1;
        case (r.phase)
            ise_pkg::PH_DECODE: begin
                next_r.active = taken;
                if (taken) begin
                    case (INSTR[ise_pkg::OPC_HI:ise_pkg::OPC_LO])
                        ise_pkg::OP_INCREMENT_SKIP:     next_r.kind = ise_pkg::ISE_INCSZ;
                        ise_pkg::OP_INCREMENT_REGISTER: next_r.kind = ise_pkg::ISE_INC;
                        default:                        next_r.kind = ise_pkg::ISE_OTHER;
                    endcase
                    next_r.dest = INSTR[ise_pkg::DEST_BIT];
                    if (acc_bit) begin
                        next_r.addr = {BANK_SELECT_REGISTER, fsel};
                    end else if (EXT_SET_EN && fsel <= ise_pkg::INDEXED_LIMIT) begin
                        next_r.addr = INDEX_BASE + {4'h0, fsel};
                    end else if (fsel < ise_pkg::ACCESS_SPLIT) begin
                        next_r.addr = {ise_pkg::ACCESS_LOW, fsel};
                    end else begin
                        next_r.addr = {ise_pkg::ACCESS_HIGH, fsel};
                    end
                end
            end
            ise_pkg::PH_READ: begin
                if (r.active) begin
                    next_r.opnd = MEM_RDATA;
                end
            end
            ise_pkg::PH_COMPUTE: begin
                if (r.active) begin
                    next_r.result = alu_bus.sum;
                end
            end
            ise_pkg::PH_WRITE: begin
                if (r.state == ise_pkg::ISE_SKIP) begin
                    next_r.skip_left = r.skip_left - 2'h1;
                    if (r.skip_left == ise_pkg::SKIP_ONE_WORD) begin
                        next_r.state = ise_pkg::ISE_EXEC;
                    end
                end else if (r.active && r.kind != ise_pkg::ISE_OTHER) begin
                    if (!r.dest) begin
                        next_r.accum = r.result;
                    end
                    if (r.kind == ise_pkg::ISE_INC) begin
                        next_r.zero   = alu_bus.zero;
                        next_r.carry  = alu_bus.carry;
                        next_r.dcarry = alu_bus.dcarry;
                        next_r.neg    = alu_bus.neg;
                        next_r.ovf    = alu_bus.ovf;
                    end
                    if (skip_now) begin
                        next_r.state     = ise_pkg::ISE_SKIP;
                        next_r.skip_left = NEXT_TWO_WORD ? ise_pkg::SKIP_TWO_WORD
                                                         : ise_pkg::SKIP_ONE_WORD;
                    end
                end
                next_r.active = 1'b0;
            end
            default: next_r.phase = ise_pkg::PH_DECODE;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            r <= '{state: ise_pkg::ISE_EXEC, kind: ise_pkg::ISE_OTHER,
                   phase: ise_pkg::PH_DECODE, active: 1'b0, dest: 1'b0,
                   addr: ise_pkg::ADDR_RESET, opnd: 8'h00, result: 8'h00,
                   skip_left: 2'h0, accum: ise_pkg::ACCUM_RESET, zero: 1'b0,
                   carry: 1'b0, dcarry: 1'b0, neg: 1'b0, ovf: 1'b0};
        end else begin
            r <= next_r;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_decode_skip_op: assert property (taken && INSTR[15:10] == 6'h0f
        |=> r.kind == ise_pkg::ISE_INCSZ && r.active)
        else $error("skip-increment opcode not decoded");
    a_dest_accum: assert property (r.active && r.kind != ise_pkg::ISE_OTHER
        && r.phase == 2'h3 && !r.dest |=> ACCUM == $past(r.opnd) + 8'h01 && !$past(MEM_WE))
        else $error("accumulator not loaded with incremented value");
    a_dest_file: assert property (r.active && r.kind != ise_pkg::ISE_OTHER
        && r.phase == 2'h3 && r.dest |-> MEM_WE && MEM_WDATA == r.opnd + 8'h01)
        else $error("file register not written back");
    a_skip_flush: assert property (r.active && r.kind == ise_pkg::ISE_INCSZ
        && r.phase == 2'h3 && r.opnd == 8'hff |-> FLUSH ##1 !INSTR_READY)
        else $error("zero result did not flush next instruction");
    a_bank_select: assert property (taken && INSTR[8]
        |=> MEM_ADDR == {$past(BANK_SELECT_REGISTER), $past(INSTR[7:0])})
        else $error("banked address wrong");
    a_indexed_addr: assert property (taken && !INSTR[8] && EXT_SET_EN
        && INSTR[7:0] <= 8'h5f |=> MEM_ADDR == $past(INDEX_BASE) + {4'h0, $past(INSTR[7:0])})
        else $error("indexed literal offset address wrong");
    a_skip_one: assert property (FLUSH && !NEXT_TWO_WORD
        |=> !INSTR_READY [*4] ##1 INSTR_READY)
        else $error("single skip not exactly one nop cycle");
    a_skip_two: assert property (FLUSH && NEXT_TWO_WORD
        |=> !INSTR_READY [*8] ##1 INSTR_READY)
        else $error("two-word skip not exactly two nop cycles");
    a_phase_seq: assert property (taken
        |=> r.phase == 2'h1 ##1 r.phase == 2'h2 && !MEM_WE ##1 r.phase == 2'h3)
        else $error("phase sequence broken");
    a_wrap_flags: assert property (r.active && r.kind == ise_pkg::ISE_INC
        && r.phase == 2'h3 && r.opnd == 8'hff |=> FLAG_ZERO && FLAG_CARRY && DIGIT_CARRY_FLAG)
        else $error("wrap did not set zero, carry and digit carry");
    a_skip_flags: assert property (r.active && r.kind == ise_pkg::ISE_INCSZ
        && r.phase == 2'h3 |=> $stable({FLAG_ZERO, FLAG_CARRY, DIGIT_CARRY_FLAG, FLAG_NEG, FLAG_OVF}))
        else $error("skip-increment changed a status flag");

    // decode of the other opcodes
    a_decode_inc_op: assert property (taken && INSTR[15:10] == 6'h0a
        |=> r.kind == ise_pkg::ISE_INC && r.active)
        else $error("plain increment opcode not decoded");
    a_decode_other: assert property (taken && INSTR[15:10] != 6'h0f
        && INSTR[15:10] != 6'h0a |=> r.kind == ise_pkg::ISE_OTHER)
        else $error("foreign opcode decoded as an increment");
    a_other_quiet: assert property (r.active && r.kind == ise_pkg::ISE_OTHER
        |-> !MEM_WE && !FLUSH)
        else $error("foreign opcode wrote or flushed");
    a_other_state: assert property (r.active && r.kind == ise_pkg::ISE_OTHER
        && r.phase == 2'h3
        |=> $stable({ACCUM, FLAG_ZERO, FLAG_CARRY, DIGIT_CARRY_FLAG, FLAG_NEG, FLAG_OVF}))
        else $error("foreign opcode changed accumulator or flags");
    a_file_keeps_acc: assert property (r.active && r.kind != ise_pkg::ISE_OTHER
        && r.phase == 2'h3 && r.dest |=> $stable(ACCUM))
        else $error("file destination disturbed the accumulator");

    // skip control
    a_flush_cause: assert property (FLUSH
        |-> r.kind == ise_pkg::ISE_INCSZ && r.opnd == 8'hff)
        else $error("flush without a zero skip-increment result");
    a_plain_next: assert property (r.active && r.kind == ise_pkg::ISE_INC
        && r.phase == 2'h3 |-> !FLUSH ##1 INSTR_READY)
        else $error("plain increment skipped");
    a_skip_quiet: assert property (r.state == ise_pkg::ISE_SKIP
        |-> !MEM_WE && !FLUSH && !INSTR_READY)
        else $error("nop cycle did work");
    a_no_skip_go: assert property (r.active && r.kind == ise_pkg::ISE_INCSZ
        && r.phase == 2'h3 && r.opnd != 8'hff |-> !FLUSH ##1 INSTR_READY)
        else $error("non-zero skip-increment not one cycle");
    a_skip_count: assert property (r.state == ise_pkg::ISE_SKIP
        |-> r.skip_left == 2'h1 || r.skip_left == 2'h2)
        else $error("flushed cycle count out of range");

    // access bank addressing
    a_access_low: assert property (taken && !INSTR[8] && !INSTR[7]
        && !(EXT_SET_EN && INSTR[7:0] <= 8'h5f)
        |=> MEM_ADDR == {4'h0, $past(INSTR[7:0])})
        else $error("low access bank address wrong");
    a_access_high: assert property (taken && !INSTR[8] && INSTR[7]
        |=> MEM_ADDR == {4'hf, $past(INSTR[7:0])})
        else $error("high access bank address wrong");

    // phase timing
    a_write_phase: assert property (MEM_WE
        |-> r.phase == ise_pkg::PH_WRITE)
        else $error("write outside the write phase");
    a_addr_holds: assert property (r.active
        |=> $stable(MEM_ADDR))
        else $error("address moved inside an instruction cycle");
    a_ready_quarter: assert property (INSTR_READY
        |=> !INSTR_READY [*3])
        else $error("ready more than once per instruction cycle");

    // plain increment flags
    a_inc_zero_carry: assert property (r.active && r.kind == ise_pkg::ISE_INC
        && r.phase == 2'h3 |=> FLAG_ZERO == ($past(r.opnd) == 8'hff) && FLAG_CARRY == FLAG_ZERO)
        else $error("zero or carry flag wrong");
    a_inc_dcarry: assert property (r.active && r.kind == ise_pkg::ISE_INC
        && r.phase == 2'h3 |=> DIGIT_CARRY_FLAG == ($past(r.opnd[3:0]) == 4'hf))
        else $error("digit carry flag wrong");
    a_inc_neg_ovf: assert property (r.active && r.kind == ise_pkg::ISE_INC
        && r.phase == 2'h3 |=> FLAG_NEG == (($past(r.opnd) + 8'h01) >= 8'h80)
        && FLAG_OVF == ($past(r.opnd) == 8'h7f))
        else $error("negative or overflow flag wrong");
endmodule

/* ise_pkg.sv */
// What this block does
// - decode skip-increment from top bits 0011 11da
// - add one; d=0 to accumulator, else file
// - zero result flushes prefetched instruction, runs nop
// - a=0 access bank, a=1 bank select register
// - indexed literal offset when a=0, extended, f<=5Fh
// - one word; one, two or three cycles
// - phases: decode, read, compute, write destination
// - FFh wraps; plain increment sets zero, carry, digit carry; skip-increment leaves flags unchanged
package ise_pkg;
    // opcode top six bits
    localparam logic [5:0] OP_INCREMENT_REGISTER = 6'h0a;
    localparam logic [5:0] OP_INCREMENT_SKIP     = 6'h0f;
    // instruction word field positions
    localparam int OPC_HI    = 15;
    localparam int OPC_LO    = 10;
    localparam int DEST_BIT  = 9;
    localparam int ACC_BIT   = 8;
    localparam int FILE_HI   = 7;
    // addressing limits
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT  = 8'h80;
    localparam logic [3:0] ACCESS_LOW    = 4'h0;
    localparam logic [3:0] ACCESS_HIGH   = 4'hf;
    // phases of one instruction cycle
    localparam logic [1:0] PH_DECODE  = 2'h0;
    localparam logic [1:0] PH_READ    = 2'h1;
    localparam logic [1:0] PH_COMPUTE = 2'h2;
    localparam logic [1:0] PH_WRITE   = 2'h3;
    // flushed cycles after a skip
    localparam logic [1:0] SKIP_ONE_WORD = 2'h1;
    localparam logic [1:0] SKIP_TWO_WORD = 2'h2;
    // reset values
    localparam logic [7:0]  ACCUM_RESET = 8'h00;
    localparam logic [11:0] ADDR_RESET  = 12'h000;

    typedef enum logic {ISE_EXEC, ISE_SKIP} ise_state_t;
    typedef enum logic [1:0] {ISE_OTHER, ISE_INC, ISE_INCSZ} ise_kind_t;

    typedef struct packed {
        ise_state_t  state;
        ise_kind_t   kind;
        logic [1:0]  phase;
        logic        active;
        logic        dest;
        logic [11:0] addr;
        logic [7:0]  opnd;
        logic [7:0]  result;
        logic [1:0]  skip_left;
        logic [7:0]  accum;
        logic        zero;
        logic        carry;
        logic        dcarry;
        logic        neg;
        logic        ovf;
    } ise_regs_t;
endpackage

/* ise_alu_if.sv */
interface ise_alu_if;
    logic [7:0] opnd;
    logic [7:0] sum;
    logic       carry;
    logic       dcarry;
    logic       zero;
    logic       neg;
    logic       ovf;

    modport alu  (input opnd, output sum, carry, dcarry, zero, neg, ovf);
    modport core (output opnd, input sum, carry, dcarry, zero, neg, ovf);
endinterface

/* ise_alu.sv */
module ise_alu (
    ise_alu_if.alu a
);
    logic [8:0] wide;

    // add one and derive the flags of the addition
    always_comb begin
        wide     = {1'b0, a.opnd} + 9'h001;
        a.sum    = wide[7:0];
        a.carry  = wide[8];
        a.dcarry = (a.opnd[3:0] == 4'hf);
        a.zero   = (wide[7:0] == 8'h00);
        a.neg    = wide[7];
        a.ovf    = (a.opnd == 8'h7f);
    end
endmodule

/* ise_testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst;
    logic [15:0] instr;
    logic        instr_valid;
    logic        next_two_word;
    logic        instr_ready;
    logic        flush;
    logic        ext_set_en;
    logic [3:0]  bank;
    logic [11:0] index_base;
    logic [11:0] mem_addr;
    logic [7:0]  mem_rdata;
    logic        mem_we;
    logic [7:0]  mem_wdata;
    logic [7:0]  accum;
    logic        fz, fc, fdc, fn, fo;
    int          miscompares = 0;
    int          n_compared = 0;
    int          cycles = 0;

    ise_core dut (
        .CLK(clk), .RST(rst), .INSTR(instr), .INSTR_VALID(instr_valid),
        .NEXT_TWO_WORD(next_two_word), .INSTR_READY(instr_ready), .FLUSH(flush),
        .EXT_SET_EN(ext_set_en), .BANK_SELECT_REGISTER(bank), .INDEX_BASE(index_base),
        .MEM_ADDR(mem_addr), .MEM_RDATA(mem_rdata), .MEM_WE(mem_we), .MEM_WDATA(mem_wdata),
        .ACCUM(accum), .FLAG_ZERO(fz), .FLAG_CARRY(fc), .DIGIT_CARRY_FLAG(fdc),
        .FLAG_NEG(fn), .FLAG_OVF(fo)
    );

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 400) begin
            miscompares++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chkf(input logic [7:0] acc, input logic [4:0] f);
        chk({4'h0, accum}, {4'h0, acc}, "accum");
        chk({7'h00, fz, fc, fdc, fn, fo}, {7'h00, f}, "flags zero carry digit-carry neg ovf");
    endtask

    // one instruction: take, check address, write phase, then stall length
    task automatic exec(input logic [15:0] w, input logic [7:0] rd, input logic tw,
                        input logic [11:0] ea, input logic ewe, input logic [7:0] ewd,
                        input logic efl, input logic [3:0] ewait, input logic ca);
        int n;
        n = 0;
        while (instr_ready !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        instr = w;
        instr_valid = 1'b1;
        mem_rdata = rd;
        next_two_word = tw;
        @(negedge clk);
        instr_valid = 1'b0;
        chk({11'h000, instr_ready}, 12'h000, "ready after take");
        if (ca) chk(mem_addr, ea, "address");
        @(negedge clk);
        @(negedge clk);
        chk({11'h000, mem_we}, {11'h000, ewe}, "write enable");
        if (ewe) chk({4'h0, mem_wdata}, {4'h0, ewd}, "write data");
        chk({11'h000, flush}, {11'h000, efl}, "flush");
        n = 0;
        @(negedge clk);
        while (instr_ready !== 1'b1 && n < 12) begin
            @(negedge clk);
            n++;
        end
        chk(n[11:0], {8'h00, ewait}, "stall cycles");
    endtask

    initial begin
        rst = 1'b1;
        instr = 16'h0000;
        instr_valid = 1'b0;
        next_two_word = 1'b0;
        ext_set_en = 1'b0;
        bank = 4'h5;
        index_base = 12'h300;
        mem_rdata = 8'h00;
        repeat (5) @(negedge clk);
        rst = 1'b0;
        exec(16'h2a10, 8'hff, 1'b0, 12'h010, 1'b1, 8'h00, 1'b0, 4'h0, 1'b1);
        chkf(8'h00, 5'b11100);
        exec(16'h2810, 8'h0f, 1'b0, 12'h010, 1'b0, 8'h00, 1'b0, 4'h0, 1'b1);
        chkf(8'h10, 5'b00100);
        exec(16'h3f33, 8'h41, 1'b0, 12'h533, 1'b1, 8'h42, 1'b0, 4'h0, 1'b1);
        chkf(8'h10, 5'b00100);
        ext_set_en = 1'b1;
        exec(16'h3c20, 8'hff, 1'b0, 12'h320, 1'b0, 8'h00, 1'b1, 4'h4, 1'b1);
        chkf(8'h00, 5'b00100);
        exec(16'h3e90, 8'hff, 1'b1, 12'hf90, 1'b1, 8'h00, 1'b1, 4'h8, 1'b1);
        exec(16'h285f, 8'h7f, 1'b0, 12'h35f, 1'b0, 8'h00, 1'b0, 4'h0, 1'b1);
        chkf(8'h80, 5'b00111);
        exec(16'h2860, 8'h00, 1'b0, 12'h060, 1'b0, 8'h00, 1'b0, 4'h0, 1'b1);
        chkf(8'h01, 5'b00000);
        exec(16'h3c60, 8'hfe, 1'b1, 12'h060, 1'b0, 8'h00, 1'b0, 4'h0, 1'b1);
        chkf(8'hff, 5'b00000);
        exec(16'h0010, 8'hff, 1'b0, 12'h000, 1'b0, 8'h00, 1'b0, 4'h0, 1'b0);
        chkf(8'hff, 5'b00000);
        tally_and_finish();
    end
endmodule
